/* File: common/irq_pkg.sv */
/*
 * shared constants and types of the cascaded interrupt controller:
 * i/o port addresses, command word bit positions, reset values, state codes.
 * assumes an 8-bit i/o port space addressed by a 16-bit port number.
 */
package irq_pkg;

   // i/o port numbers
   localparam logic [15:0] MASTER_CMD_ADDR  = 16'h0020;
   localparam logic [15:0] MASTER_MASK_ADDR = 16'h0021;
   localparam logic [15:0] SLAVE_CMD_ADDR   = 16'h00A0;
   localparam logic [15:0] SLAVE_MASK_ADDR  = 16'h00A1;
   localparam logic [15:0] MASTER_TRIG_ADDR = 16'h04D0;
   localparam logic [15:0] SLAVE_TRIG_ADDR  = 16'h04D1;

   // command word bit positions
   localparam int FIRST_INIT_BIT   = 4;
   localparam int FIRST_LEVEL_BIT  = 3;
   localparam int FIRST_SINGLE_BIT = 1;
   localparam int FIRST_WORD4_BIT  = 0;
   localparam int ICW4_AEOI_BIT = 1;
   localparam int OCW_SEL_HI    = 4;
   localparam int OCW_SEL_LO    = 3;
   localparam int OCW2_SL_BIT   = 6;
   localparam int OCW2_EOI_BIT  = 5;
   localparam int OCW3_RR_BIT   = 1;
   localparam int OCW3_RIS_BIT  = 0;
   localparam logic [1:0] OCW2_SEL = 2'h0;
   localparam logic [1:0] OCW3_SEL = 2'h1;

   // fixed line assignments inside a bank
   localparam logic [2:0] CASCADE_LINE = 3'h2;
   localparam logic [2:0] DEFAULT_LINE = 3'h7;

   // reset values
   localparam logic [4:0] RESET_VECTOR_BASE = 5'h00;
   localparam logic [7:0] RESET_MASK        = 8'h00;
   localparam logic [7:0] RESET_TRIG        = 8'h00;

   // initialisation sequence, gray along icw2, icw3, icw4
   typedef enum logic [1:0] {
      INIT_READY = 2'h0,
      INIT_ICW2  = 2'h1,
      INIT_ICW3  = 2'h3,
      INIT_ICW4  = 2'h2
   } init_t;

   // acknowledge sequence
   typedef enum logic [0:0] {
      ACK_IDLE  = 1'h0,
      ACK_WAIT2 = 1'h1
   } ack_t;

   typedef struct packed {
      init_t      init;
      logic       bank_trigger_select;
      logic       single;
      logic       ic4;
      logic       aeoi;
      logic [4:0] base;
      logic [7:0] imr;
      logic [7:0] in_service_bits;
      logic       read_isr;
      logic [7:0] trig;
   } bank_t;

   localparam bank_t BANK_RESET = '{INIT_READY, 1'b0, 1'b0, 1'b0, 1'b0,
      RESET_VECTOR_BASE, RESET_MASK, 8'h00, 1'b0, RESET_TRIG};

endpackage

/* File: design/req_capture.sv */
/*
 * per-line request capture for one bank: rising edge latch or level pass.
 * assumes lines are already active high and synchronous to clk.
 */
`timescale 1ns/1ps
module req_capture #(
   parameter int N = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // lines and control
   input  wire logic [N-1:0] line,
   input  wire logic [N-1:0] level_mode,
   input  wire logic [N-1:0] clr,
   // pending requests
   output logic      [N-1:0] irr
);
   typedef struct packed {
      logic [N-1:0] prev;
      logic [N-1:0] armed;
   } cap_t;

   cap_t q, d;

   if (N < 1) begin : g_bad_n
      $error("req_capture needs at least one line");
   end

   // a new edge wins over a clear in the same cycle
   always_comb begin
      d.prev  = line;
      d.armed = (q.armed & ~clr) | (line & ~q.prev);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // an edge request vanishes once its line drops again
   for (genvar i = 0; i < N; i++) begin : g_line
      assign irr[i] = level_mode[i] ? line[i] : (q.armed[i] & line[i]);
   end
endmodule

/* File: design/prio_pick.sv */
/*
 * fully nested priority pick for one bank: line 0 highest, line 7 lowest.
 * assumes req is already masked; pure combinational.
 */
`timescale 1ns/1ps
module prio_pick (
   // inputs
   input  wire logic [7:0] req,
   input  wire logic [7:0] in_service_bits,
   // choice
   output logic            any,
   output logic      [2:0] idx
);
   // a line in service blocks itself and all lower priorities
   always_comb begin
      logic blocked;
      blocked = 1'b0;
      any     = 1'b0;
      idx     = 3'h0;
      for (int i = 0; i < 8; i++) begin
         blocked = blocked | in_service_bits[i];
         if (!blocked && !any && req[i]) begin
            any = 1'b1;
            idx = 3'(i);
         end
      end
   end
endmodule

/* File: design/cascade_irq.sv */
/*
 * two cascaded interrupt controller banks with i/o ports, trigger select,
 * acknowledge sequence and vector delivery.
 * assumes all inputs are synchronous to clk; io_wr and io_rd are one-cycle
 * strobes; the processor gives two acknowledge strobes per interrupt.
 */
`timescale 1ns/1ps
module cascade_irq #(
   parameter int PER_LINE = 1
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // i/o port access
   input  wire logic [15:0] io_addr,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   output logic      [7:0]  io_rdata,
   // request sources
   input  wire logic [15:0] irq_ext,
   input  wire logic        timer_out,
   input  wire logic        coproc_error_request_line,
   input  wire logic        coproc_error_int,
   input  wire logic        coproc_internal_en,
   input  wire logic        mouse_request_line,
   input  wire logic        mouse_int,
   input  wire logic        mouse_internal_en,
   // processor side
   input  wire logic        acknowledge_strobe_n,
   output logic             cpu_int,
   output logic      [7:0]  vector,
   output logic             vector_valid
);
   typedef struct packed {
      irq_pkg::bank_t [1:0] bank;
      irq_pkg::ack_t        ack;
      logic                 ack_prev;
      logic                 sel_slave;
      logic                 dflt_m;
      logic                 dflt_s;
      logic [2:0]           m_idx;
      logic [2:0]           s_idx;
      logic [7:0]           rdata;
      logic [7:0]           vec;
      logic                 vec_valid;
      logic                 int_out;
   } state_t;

   state_t q, d;

   logic [1:0][7:0] raw;
   logic [1:0][7:0] line_eff;
   logic [1:0][7:0] lvl;
   logic [1:0][7:0] clr;
   logic [1:0][7:0] irr;
   logic [1:0][7:0] req;
   logic [1:0]      any;
   logic [1:0][2:0] idx;
   logic            s_int;
   logic            ack_fall;

   if (PER_LINE != 0 && PER_LINE != 1) begin : g_bad_variant
      $error("PER_LINE must be 0 or 1");
   end

   // slave output drops during an acknowledge so a new one gives an edge
   assign s_int    = any[1] && (q.ack == irq_pkg::ACK_IDLE);
   assign ack_fall = q.ack_prev && !acknowledge_strobe_n;

   // line routing: timer on 0, slave on 2, optional internal 12 and 13
   assign raw[0] = {irq_ext[7:3], s_int, irq_ext[1], timer_out};
   assign raw[1] = {irq_ext[15:14],
                    coproc_internal_en ? coproc_error_int
                                       : coproc_error_request_line,
                    mouse_internal_en ? mouse_int : mouse_request_line,
                    irq_ext[11:8]};

   // per-bank capture and priority pick
   for (genvar b = 0; b < 2; b++) begin : g_bank
      // per-line level mode is active low, bank level mode active high
      assign lvl[b] = (PER_LINE != 0) ? q.bank[b].trig
                                      : {8{q.bank[b].bank_trigger_select}};
      assign line_eff[b] = (PER_LINE != 0) ? (raw[b] ^ q.bank[b].trig)
                                           : raw[b];
      assign req[b] = irr[b] & ~q.bank[b].imr;

      req_capture #(
         .N (8)
      ) u_cap (
         .clk        (clk),
         .rst        (rst),
         .line       (line_eff[b]),
         .level_mode (lvl[b]),
         .clr        (clr[b]),
         .irr        (irr[b])
      );

      prio_pick u_pick (
         .req (req[b]),
         .in_service_bits (q.bank[b].in_service_bits),
         .any (any[b]),
         .idx (idx[b])
      );
   end

   // next state: port writes first, acknowledge last so a set wins
   always_comb begin
      logic        found;
      logic [15:0] cmd_a;
      logic [15:0] mask_a;
      logic [15:0] trig_a;
      found        = 1'b0;
      cmd_a        = 16'h0000;
      mask_a       = 16'h0000;
      trig_a       = 16'h0000;
      d            = q;
      clr          = '0;
      d.ack_prev   = acknowledge_strobe_n;
      d.vec_valid  = 1'b0;

      for (int b = 0; b < 2; b++) begin
         cmd_a  = (b == 0) ? irq_pkg::MASTER_CMD_ADDR : irq_pkg::SLAVE_CMD_ADDR;
         mask_a = (b == 0) ? irq_pkg::MASTER_MASK_ADDR : irq_pkg::SLAVE_MASK_ADDR;
         trig_a = (b == 0) ? irq_pkg::MASTER_TRIG_ADDR : irq_pkg::SLAVE_TRIG_ADDR;
         found  = 1'b0;
         // command port: init word, end command, read select
         if (io_wr && io_addr == cmd_a) begin
            if (io_wdata[irq_pkg::FIRST_INIT_BIT]) begin
               d.bank[b].init     = irq_pkg::INIT_ICW2;
               d.bank[b].bank_trigger_select = io_wdata[irq_pkg::FIRST_LEVEL_BIT];
               d.bank[b].single   = io_wdata[irq_pkg::FIRST_SINGLE_BIT];
               d.bank[b].ic4      = io_wdata[irq_pkg::FIRST_WORD4_BIT];
               d.bank[b].aeoi     = 1'b0;
               d.bank[b].imr      = irq_pkg::RESET_MASK;
               d.bank[b].in_service_bits      = 8'h00;
               d.bank[b].read_isr = 1'b0;
               clr[b]             = 8'hFF;
            end else if (io_wdata[irq_pkg::OCW_SEL_HI:irq_pkg::OCW_SEL_LO]
                         == irq_pkg::OCW2_SEL) begin
               if (io_wdata[irq_pkg::OCW2_EOI_BIT]) begin
                  if (io_wdata[irq_pkg::OCW2_SL_BIT]) begin
                     d.bank[b].in_service_bits[io_wdata[2:0]] = 1'b0;
                  end else begin
                     // non-specific: the lowest-numbered (highest priority) bit in service goes
                     for (int j = 0; j < 8; j++) begin
                        if (!found && q.bank[b].in_service_bits[j]) begin
                           d.bank[b].in_service_bits[j] = 1'b0;
                           found            = 1'b1;
                        end
                     end
                  end
               end
            end else if (io_wdata[irq_pkg::OCW_SEL_HI:irq_pkg::OCW_SEL_LO]
                         == irq_pkg::OCW3_SEL) begin
               if (io_wdata[irq_pkg::OCW3_RR_BIT]) begin
                  d.bank[b].read_isr = io_wdata[irq_pkg::OCW3_RIS_BIT];
               end
            end
         end
         // mask port: init sequence words, else the mask
         if (io_wr && io_addr == mask_a) begin
            unique case (q.bank[b].init)
               irq_pkg::INIT_READY: begin
                  d.bank[b].imr = io_wdata;
               end
               irq_pkg::INIT_ICW2: begin
                  d.bank[b].base = io_wdata[7:3];
                  if (!q.bank[b].single) begin
                     d.bank[b].init = irq_pkg::INIT_ICW3;
                  end else if (q.bank[b].ic4) begin
                     d.bank[b].init = irq_pkg::INIT_ICW4;
                  end else begin
                     d.bank[b].init = irq_pkg::INIT_READY;
                  end
               end
               irq_pkg::INIT_ICW3: begin
                  // cascade wiring is fixed, the word only steps the sequence
                  d.bank[b].init = q.bank[b].ic4 ? irq_pkg::INIT_ICW4
                                                 : irq_pkg::INIT_READY;
               end
               irq_pkg::INIT_ICW4: begin
                  d.bank[b].aeoi = io_wdata[irq_pkg::ICW4_AEOI_BIT];
                  d.bank[b].init = irq_pkg::INIT_READY;
               end
            endcase
         end
         // per-line trigger select exists only in that variant
         if (PER_LINE != 0 && io_wr && io_addr == trig_a) begin
            d.bank[b].trig = io_wdata;
         end
      end

      // read data is registered; unmapped ports read zero
      if (io_rd) begin
         unique case (io_addr)
            irq_pkg::MASTER_CMD_ADDR:
               d.rdata = q.bank[0].read_isr ? q.bank[0].in_service_bits : irr[0];
            irq_pkg::SLAVE_CMD_ADDR:
               d.rdata = q.bank[1].read_isr ? q.bank[1].in_service_bits : irr[1];
            irq_pkg::MASTER_MASK_ADDR: d.rdata = q.bank[0].imr;
            irq_pkg::SLAVE_MASK_ADDR:  d.rdata = q.bank[1].imr;
            irq_pkg::MASTER_TRIG_ADDR:
               d.rdata = (PER_LINE != 0) ? q.bank[0].trig : 8'h00;
            irq_pkg::SLAVE_TRIG_ADDR:
               d.rdata = (PER_LINE != 0) ? q.bank[1].trig : 8'h00;
            default: d.rdata = 8'h00;
         endcase
      end

      // acknowledge sequence
      unique case (q.ack)
         irq_pkg::ACK_IDLE: begin
            if (ack_fall) begin
               d.ack       = irq_pkg::ACK_WAIT2;
               d.sel_slave = 1'b0;
               d.dflt_m    = 1'b0;
               d.dflt_s    = 1'b0;
               if (any[0] && idx[0] == irq_pkg::CASCADE_LINE
                   && !q.bank[0].single) begin
                  // slave requests take the master line 2 slot
                  d.sel_slave                              = 1'b1;
                  d.m_idx                                  = idx[0];
                  d.bank[0].in_service_bits[irq_pkg::CASCADE_LINE]     = 1'b1;
                  clr[0][irq_pkg::CASCADE_LINE]            = 1'b1;
                  if (any[1]) begin
                     d.s_idx                 = idx[1];
                     d.bank[1].in_service_bits[idx[1]]   = 1'b1;
                     clr[1][idx[1]]          = 1'b1;
                  end else begin
                     d.s_idx  = irq_pkg::DEFAULT_LINE;
                     d.dflt_s = 1'b1;
                  end
               end else if (any[0]) begin
                  d.m_idx               = idx[0];
                  d.bank[0].in_service_bits[idx[0]] = 1'b1;
                  clr[0][idx[0]]        = 1'b1;
               end else begin
                  // request vanished before the strobe: no bit in service
                  d.m_idx  = irq_pkg::DEFAULT_LINE;
                  d.dflt_m = 1'b1;
               end
            end
         end
         irq_pkg::ACK_WAIT2: begin
            if (ack_fall) begin
               d.ack       = irq_pkg::ACK_IDLE;
               d.vec_valid = 1'b1;
               if (q.sel_slave) begin
                  d.vec = {q.bank[1].base, q.s_idx};
               end else begin
                  d.vec = {q.bank[0].base, q.m_idx};
               end
               // automatic end of service clears at the second strobe
               if (q.bank[0].aeoi && !q.dflt_m) begin
                  d.bank[0].in_service_bits[q.m_idx] = 1'b0;
               end
               if (q.bank[1].aeoi && q.sel_slave && !q.dflt_s) begin
                  d.bank[1].in_service_bits[q.s_idx] = 1'b0;
               end
            end
         end
      endcase

      d.int_out = any[0] && (d.ack == irq_pkg::ACK_IDLE);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q      <= '0;
         q.bank <= {irq_pkg::BANK_RESET, irq_pkg::BANK_RESET};
      end else begin
         q <= d;
      end
   end

   assign io_rdata     = q.rdata;
   assign cpu_int      = q.int_out;
   assign vector       = q.vec;
   assign vector_valid = q.vec_valid;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // a vanished master request answers line 7 and leaves the master service bits alone
   a_default_no_service: assert property (
      (q.ack == irq_pkg::ACK_IDLE && ack_fall && !any[0] && !io_wr)
      |=> (q.bank[0].in_service_bits == $past(q.bank[0].in_service_bits)) && q.m_idx == 3'h7)
      else $error("default line 7 changed the service bits");

   a_default_vector: assert property (
      (q.ack == irq_pkg::ACK_WAIT2 && ack_fall && (q.sel_slave ? q.dflt_s : q.dflt_m))
      |=> vector[2:0] == 3'h7 && vector_valid)
      else $error("vanished request did not give line 7");

   // genuine master request sets its service bit
   a_genuine_service: assert property (
      (q.ack == irq_pkg::ACK_IDLE && ack_fall && any[0]
       && idx[0] != irq_pkg::CASCADE_LINE)
      |=> q.bank[0].in_service_bits[q.m_idx] && !q.dflt_m)
      else $error("acknowledged request not in service");

   // vector appears one cycle after the second strobe only
   a_vector_timing: assert property (
      vector_valid |-> $past(ack_fall) && $past(q.ack) == irq_pkg::ACK_WAIT2)
      else $error("vector without a second acknowledge");

   // line 0 wins when nothing is in service
   a_prio_order: assert property (
      (req[0][0] && q.bank[0].in_service_bits == 8'h00) |-> any[0] && idx[0] == 3'h0)
      else $error("line 0 lost priority");

   // slave choice goes through the master line 2 slot
   a_slave_slot: assert property (
      (q.ack == irq_pkg::ACK_IDLE && ack_fall
       && any[0] && idx[0] == irq_pkg::CASCADE_LINE && !q.bank[0].single)
      |=> q.sel_slave && q.bank[0].in_service_bits[2])
      else $error("slave request bypassed the cascade slot");

   // a held-high edge line gives no new request after its acknowledge
   a_edge_held_high: assert property (
      (lvl[0][3] == 1'b0 && clr[0][3] && line_eff[0][3] && $past(line_eff[0][3]))
      ##1 line_eff[0][3] |-> !irr[0][3])
      else $error("held line requested again in edge mode");

   // bank level mode follows the high level
   a_level_follow: assert property (
      (PER_LINE == 0 && q.bank[1].bank_trigger_select && raw[1][3]) |-> irr[1][3])
      else $error("high level not recognised in level mode");

   // per-line level mode answers to a low line
   a_low_level: assert property (
      (PER_LINE != 0 && q.bank[1].trig[3] && !raw[1][3]) |-> irr[1][3])
      else $error("low level not recognised in per-line mode");

   // end command with one bit in service clears it
   a_eoi_clears: assert property (
      (io_wr && io_addr == irq_pkg::MASTER_CMD_ADDR && io_wdata == 8'h20
       && q.bank[0].in_service_bits == 8'h08 && !ack_fall) |=> q.bank[0].in_service_bits == 8'h00)
      else $error("end command left the bit in service");

   // selected internal sources drive lines 12 and 13
   a_internal_lines: assert property (
      (coproc_internal_en && mouse_internal_en)
      |-> raw[1][5] == coproc_error_int && raw[1][4] == mouse_int)
      else $error("internal source not routed");
endmodule

/* File: test/host_ack.sv */
/*
 * processor-side model: two acknowledge strobes per interrupt, vector capture.
 * assumes the device marks the vector with a one-cycle valid pulse.
 */
`timescale 1ns/1ps
module host_ack (
   // clock
   input  wire logic       clk,
   // bench request
   input  wire logic       go,
   output logic            busy,
   output logic      [7:0] vec,
   // processor lines
   output logic            acknowledge_strobe_n,
   input  wire logic [7:0] vector,
   input  wire logic       vector_valid
);
   initial begin
      busy = 1'b0;
      vec = 8'h00;
      acknowledge_strobe_n = 1'b1;
   end

   // one low cycle per strobe, a high cycle between; vector unknown until seen
   always @(posedge clk) begin
      if (go) begin
         busy = 1'b1;
         vec = 8'hxx;
         #1 acknowledge_strobe_n = 1'b0;
         @(posedge clk) #1 acknowledge_strobe_n = 1'b1;
         @(posedge clk) #1 acknowledge_strobe_n = 1'b0;
         @(posedge clk) #1 acknowledge_strobe_n = 1'b1;
         // valid stands one cycle from the edge of the second strobe, look first
         repeat (4) begin
            if (vector_valid === 1'b1) vec = vector;
            @(posedge clk) #1;
         end
         busy = 1'b0;
      end
   end
endmodule

/* File: test/tb_cascaded_dual_irq_controller.sv */
/*
 * testbench of the cascaded interrupt controller, per-line trigger variant.
 * assumes the host_ack model answers acknowledge cycles.
 */
`timescale 1ns/1ps
module tb_cascaded_dual_irq_controller;
   logic        clk = 0, rst = 1, io_wr = 0, io_rd = 0, timer_out = 0, go = 0;
   logic        cerl = 0, cei = 0, cen = 0, mrl = 0, mi = 0, men = 0, busy;
   logic [15:0] io_addr = 0, irq_ext = 16'h0800;
   logic [7:0]  io_wdata = 0, io_rdata, vector, vec, rdata_b;
   logic        ack_n, cpu_int, vector_valid;
   int          err_total = 0, checked = 0;

   always #20 clk = ~clk;

   cascade_irq DUT (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .irq_ext(irq_ext),
      .timer_out(timer_out), .coproc_error_request_line(cerl), .coproc_error_int(cei),
      .coproc_internal_en(cen), .mouse_request_line(mrl), .mouse_int(mi),
      .mouse_internal_en(men), .acknowledge_strobe_n(ack_n), .cpu_int(cpu_int),
      .vector(vector), .vector_valid(vector_valid));
   // bank trigger variant on the same stimulus; only its read data is compared
   cascade_irq #(.PER_LINE(0)) DUT_BANK (.clk(clk), .rst(rst), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(rdata_b),
      .irq_ext(irq_ext), .timer_out(timer_out), .coproc_error_request_line(cerl),
      .coproc_error_int(cei), .coproc_internal_en(cen), .mouse_request_line(mrl),
      .mouse_int(mi), .mouse_internal_en(men), .acknowledge_strobe_n(ack_n),
      .cpu_int(), .vector(), .vector_valid());
   host_ack HOST (.clk(clk), .go(go), .busy(busy), .vec(vec),
      .acknowledge_strobe_n(ack_n), .vector(vector), .vector_valid(vector_valid));

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_wr = 1;
      cyc(1);
      io_wr = 0;
      cyc(1);
   endtask
   task rd(input logic [15:0] a, input logic [7:0] exp);
      io_addr = a;
      io_rd = 1;
      cyc(1);
      io_rd = 0;
      cyc(1);
      chk(io_rdata, exp);
   endtask
   // wait for the request bounded, then run both strobes and compare the vector
   task ack(input logic [7:0] exp, input bit need);
      int i;
      for (i = 0; i < 20 && cpu_int !== 1'b1; i++) cyc(1);
      if (need) chk({7'h00, cpu_int}, 8'h01);
      go = 1;
      cyc(1);
      go = 0;
      for (i = 0; i < 20 && busy; i++) cyc(1);
      chk(vec, exp);
   endtask
   task end_of_service_command(input bit slave);
      if (slave) wr(16'h00A0, 8'h20);
      wr(16'h0020, 8'h20);
   endtask
   task quiet;
      cyc(5);
      chk({7'h00, cpu_int}, 8'h00);
   endtask
   task close_out;
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // watchdog: the tests need about 250 cycles
   initial begin
      #200000;
      err_total++;
      close_out;
   end

   initial begin
      cyc(4);
      rst = 0;
      cyc(1);
      rd(16'h0021, 8'h00);
      rd(16'h04D0, 8'h00);
      rd(16'h0030, 8'h00);
      wr(16'h0020, 8'h11);
      wr(16'h0021, 8'h08);
      wr(16'h0021, 8'h04);
      wr(16'h0021, 8'h01);
      wr(16'h00A0, 8'h19);
      wr(16'h00A1, 8'h70);
      wr(16'h00A1, 8'h02);
      wr(16'h00A1, 8'h01);
      // high slave line 11: no edge here, a level in the bank variant
      rd(16'h00A0, 8'h00);
      chk(rdata_b, 8'h08);
      // edge line held high through the first strobe and past the end command
      irq_ext[3] = 1;
      ack(8'h0B, 1);
      end_of_service_command(0);
      quiet;
      irq_ext[3] = 0;
      // slave sits between lines 1 and 3 of the master
      irq_ext[5] = 1;
      irq_ext[9] = 1;
      ack(8'h71, 1);
      end_of_service_command(1);
      ack(8'h0D, 1);
      end_of_service_command(0);
      irq_ext[5] = 0;
      irq_ext[9] = 0;
      timer_out = 1;
      ack(8'h08, 1);
      end_of_service_command(0);
      men = 1;
      mrl = 1;
      mi = 1;
      ack(8'h74, 1);
      end_of_service_command(1);
      cerl = 1;
      ack(8'h75, 1);
      end_of_service_command(1);
      cen = 1;
      cyc(2);
      cei = 1;
      ack(8'h75, 1);
      end_of_service_command(1);
      // mask holds a request back until cleared
      wr(16'h0021, 8'h08);
      rd(16'h0021, 8'h08);
      irq_ext[3] = 1;
      quiet;
      wr(16'h0021, 8'h00);
      ack(8'h0B, 1);
      end_of_service_command(0);
      irq_ext[3] = 0;
      wr(16'h0020, 8'h0B);
      // genuine line 7 sets its service bit, a vanished line does not
      irq_ext[7] = 1;
      ack(8'h0F, 1);
      rd(16'h0020, 8'h80);
      end_of_service_command(0);
      irq_ext[7] = 0;
      irq_ext[4] = 1;
      cyc(4);
      irq_ext[4] = 0;
      ack(8'h0F, 0);
      rd(16'h0020, 8'h00);
      // line 11 as low level; lines 0,1,2,8,13 stay edge
      wr(16'h04D1, 8'h08);
      rd(16'h04D1, 8'h08);
      irq_ext[11] = 0;
      ack(8'h73, 1);
      end_of_service_command(1);
      ack(8'h73, 1);
      irq_ext[11] = 1;
      end_of_service_command(1);
      quiet;
      close_out;
   end
endmodule
